/* core/scg_pkg.sv */
// Package for the sleep-mode clock gating controller.
// Assumes a 32-bit AXI4-Lite register bus and a single 40 MHz core clock.
package scg_pkg;

   // ----------------------------------------------------------------
   // Address map
   // ----------------------------------------------------------------
   localparam logic [31:0] SCG_BASE_ADDR  = 32'h400F_E000;
   localparam logic [11:0] SCG_OFS_RUN    = 12'h108;
   localparam logic [11:0] SCG_OFS_SLEEP  = 12'h118;
   localparam logic [11:0] SCG_OFS_DEEP   = 12'h128;
   localparam logic [11:0] SCG_OFS_CFG    = 12'h200;
   localparam logic [11:0] SCG_OFS_STAT   = 12'h204;
   localparam logic [11:0] SCG_OFS_MASK   = 12'h208;

   // ----------------------------------------------------------------
   // Field layout of the gating registers
   // ----------------------------------------------------------------
   localparam int          SCG_PHY_BIT    = 30;
   localparam int          SCG_MAC_BIT    = 28;
   localparam int          SCG_PORT_MSB   = 6;
   localparam logic [31:0] SCG_GATE_WMASK = 32'h5000_007F;
   localparam logic [31:0] SCG_GATE_RST   = 32'h0000_0000;

   // Configuration register fields
   localparam int          SCG_AUTO_BIT   = 0;
   localparam int          SCG_PST_LSB    = 1;
   localparam logic        SCG_AUTO_RST   = 1'b0;

   // Units: 0..6 ports A..G, 7 MAC, 8 PHY
   localparam int          SCG_UNITS      = 9;
   localparam logic [8:0]  SCG_UNITS_RST  = 9'h000;

   // ----------------------------------------------------------------
   // Bus answers
   // ----------------------------------------------------------------
   localparam logic [1:0]  SCG_RESP_OKAY  = 2'h0;
   localparam logic [1:0]  SCG_RESP_SLV   = 2'h2;

   typedef enum logic [1:0]
   {
      SCG_PS_RUN   = 2'h0,
      SCG_PS_SLEEP = 2'h1,
      SCG_PS_DEEP  = 2'h3
   } scg_pstate_e;

endpackage

/* core/scg_gate_cell.sv */
// Glitch-free clock gate for one peripheral unit.
// Assumes the enable comes from a flop on the rising edge of clk_i.
`timescale 1ns/1ps

module scg_gate_cell
(
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Enable and gated clock
   input  wire logic en_i,
   output logic      gclk_o
);

   logic en_low_r;

   // ----------------------------------------------------------------
   // Enable capture
   // ----------------------------------------------------------------
   // Enable only moves while the clock is low, so no pulse is cut short
   always_ff @(negedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         en_low_r <= 1'b0;
      else
         en_low_r <= en_i;
   end

   assign gclk_o = clk_i & en_low_r;

endmodule

/* core/scg_ctrl.sv */
// Sleep-mode clock gating controller with AXI4-Lite register slave.
// Assumes unit access strobes and power state come from core_clk logic.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps

// Overview of operation
// - Gating bit set in Sleep: unit receives its clock and works.
// - Gating bit clear in Sleep: unit clock stopped, unit held disabled.
// - Access to a unit whose clock is off answers with a bus fault.
// - Sleep gating register resets to all zeros, all units off.
// - Separate gating register applies in Run, Sleep and Deep-Sleep.
// - Sleep and Deep-Sleep registers apply only while auto gating select set.
// - Bit 30 gates the Ethernet PHY clock.
// - Bit 28 gates the Ethernet MAC clock.
// - Bits 6 to 0 gate GPIO ports G down to A.
// - Bits 31, 29, 27 to 7 read zero; writes ignored.
// - Sleep gating register decoded at offset 0x118 from base.
module scg_ctrl
(
   // Clock and reset
   input  wire logic                           core_clk,
   input  wire logic                           sys_rst,
   // AXI4-Lite write address and data
   input  wire logic [31:0]                    s_axi_awaddr,
   input  wire logic                           s_axi_awvalid,
   output logic                                s_axi_awready,
   input  wire logic [31:0]                    s_axi_wdata,
   input  wire logic [3:0]                     s_axi_wstrb,
   input  wire logic                           s_axi_wvalid,
   output logic                                s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]                          s_axi_bresp,
   output logic                                s_axi_bvalid,
   input  wire logic                           s_axi_bready,
   // AXI4-Lite read
   input  wire logic [31:0]                    s_axi_araddr,
   input  wire logic                           s_axi_arvalid,
   output logic                                s_axi_arready,
   output logic [31:0]                         s_axi_rdata,
   output logic [1:0]                          s_axi_rresp,
   output logic                                s_axi_rvalid,
   input  wire logic                           s_axi_rready,
   // Power state from the processor
   input  wire logic                           sleep_mode,
   input  wire logic                           deep_sleep_mode,
   // Peripheral side
   input  wire logic [scg_pkg::SCG_UNITS-1:0]  unit_access,
   output logic      [scg_pkg::SCG_UNITS-1:0]  unit_clk,
   output logic      [scg_pkg::SCG_UNITS-1:0]  unit_disable,
   output logic                                bus_fault,
   // Interrupt
   output logic                                irq
);
   import scg_pkg::*;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [SCG_UNITS-1:0] gate_units(input logic [31:0] r);
      gate_units = {r[SCG_PHY_BIT], r[SCG_MAC_BIT], r[SCG_PORT_MSB:0]};
   endfunction

   function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
      apply_strb = old_v;
      for (int b = 0; b < 4; b++)
         if (strb[b])
            apply_strb[8*b +: 8] = new_v[8*b +: 8];
   endfunction

   function automatic logic addr_hit(input logic [31:0] a, input logic [11:0] ofs);
      addr_hit = (a[31:12] == SCG_BASE_ADDR[31:12]) && (a[11:0] == ofs);
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic                 aw_held_r, aw_held_nxt;
   logic                 w_held_r, w_held_nxt;
   logic [31:0]          awaddr_r, awaddr_nxt;
   logic [31:0]          wdata_r, wdata_nxt;
   logic [3:0]           wstrb_r, wstrb_nxt;
   logic                 bvalid_r, bvalid_nxt;
   logic [1:0]           bresp_r, bresp_nxt;
   logic                 rvalid_r, rvalid_nxt;
   logic [1:0]           rresp_r, rresp_nxt;
   logic [31:0]          rdata_r, rdata_nxt;
   logic [31:0]          run_gate_r, run_gate_nxt;
   logic [31:0]          sleep_gate_r, sleep_gate_nxt;
   logic [31:0]          deep_gate_r, deep_gate_nxt;
   logic                 auto_gating_select_r, auto_gating_select_nxt;
   logic [SCG_UNITS-1:0] fault_stat_r, fault_stat_nxt;
   logic [SCG_UNITS-1:0] fault_mask_r, fault_mask_nxt;
   scg_pstate_e          pstate_r, pstate_nxt;
   logic [SCG_UNITS-1:0] unit_en_r, unit_en_nxt;
   logic [SCG_UNITS-1:0] disable_r, disable_nxt;
   logic                 fault_r, fault_nxt;
   logic                 irq_r, irq_nxt;
   logic                 wr_fire;
   logic [SCG_UNITS-1:0] fault_hit;
   logic [31:0]          mask_merge;

   // ----------------------------------------------------------------
   // Register bus slave
   // ----------------------------------------------------------------
   // Address and data are taken in either order; one write in flight
   assign wr_fire   = aw_held_r && w_held_r && !bvalid_r;
   assign fault_hit = unit_access & ~unit_en_r;
   assign mask_merge = apply_strb({23'h0, fault_mask_r}, wdata_r, wstrb_r);

   always_comb
   begin
      aw_held_nxt    = aw_held_r;
      w_held_nxt     = w_held_r;
      awaddr_nxt     = awaddr_r;
      wdata_nxt      = wdata_r;
      wstrb_nxt      = wstrb_r;
      bvalid_nxt     = bvalid_r;
      bresp_nxt      = bresp_r;
      rvalid_nxt     = rvalid_r;
      rresp_nxt      = rresp_r;
      rdata_nxt      = rdata_r;
      run_gate_nxt   = run_gate_r;
      sleep_gate_nxt = sleep_gate_r;
      deep_gate_nxt  = deep_gate_r;
      auto_gating_select_nxt = auto_gating_select_r;
      fault_mask_nxt = fault_mask_r;
      fault_stat_nxt = fault_stat_r;
      if (s_axi_awvalid && !aw_held_r)
      begin
         aw_held_nxt = 1'b1;
         awaddr_nxt  = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_r)
      begin
         w_held_nxt = 1'b1;
         wdata_nxt  = s_axi_wdata;
         wstrb_nxt  = s_axi_wstrb;
      end
      if (wr_fire)
      begin
         aw_held_nxt = 1'b0;
         w_held_nxt  = 1'b0;
         bvalid_nxt  = 1'b1;
         bresp_nxt   = SCG_RESP_OKAY;
         if (addr_hit(awaddr_r, SCG_OFS_RUN))
            run_gate_nxt = apply_strb(run_gate_r, wdata_r, wstrb_r) & SCG_GATE_WMASK;
         else if (addr_hit(awaddr_r, SCG_OFS_SLEEP))
            sleep_gate_nxt = apply_strb(sleep_gate_r, wdata_r, wstrb_r) & SCG_GATE_WMASK;
         else if (addr_hit(awaddr_r, SCG_OFS_DEEP))
            deep_gate_nxt = apply_strb(deep_gate_r, wdata_r, wstrb_r) & SCG_GATE_WMASK;
         else if (addr_hit(awaddr_r, SCG_OFS_CFG))
         begin
            if (wstrb_r[0])
               auto_gating_select_nxt = wdata_r[SCG_AUTO_BIT];
         end
         else if (addr_hit(awaddr_r, SCG_OFS_STAT))
            fault_stat_nxt = fault_stat_r & ~(wdata_r[SCG_UNITS-1:0]
                             & {{(SCG_UNITS-8){wstrb_r[1]}}, {8{wstrb_r[0]}}});
         else if (addr_hit(awaddr_r, SCG_OFS_MASK))
            fault_mask_nxt = mask_merge[SCG_UNITS-1:0];
         else
            bresp_nxt = SCG_RESP_SLV;
      end
      // New faults win over a clear in the same cycle
      fault_stat_nxt = fault_stat_nxt | fault_hit;
      if (bvalid_r && s_axi_bready)
         bvalid_nxt = 1'b0;
      if (rvalid_r && s_axi_rready)
         rvalid_nxt = 1'b0;
      if (s_axi_arvalid && !rvalid_r)
      begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = SCG_RESP_OKAY;
         if (addr_hit(s_axi_araddr, SCG_OFS_RUN))
            rdata_nxt = run_gate_r;
         else if (addr_hit(s_axi_araddr, SCG_OFS_SLEEP))
            rdata_nxt = sleep_gate_r;
         else if (addr_hit(s_axi_araddr, SCG_OFS_DEEP))
            rdata_nxt = deep_gate_r;
         else if (addr_hit(s_axi_araddr, SCG_OFS_CFG))
            rdata_nxt = {29'h0, pstate_r, auto_gating_select_r};
         else if (addr_hit(s_axi_araddr, SCG_OFS_STAT))
            rdata_nxt = {23'h0, fault_stat_r};
         else if (addr_hit(s_axi_araddr, SCG_OFS_MASK))
            rdata_nxt = {23'h0, fault_mask_r};
         else
         begin
            rdata_nxt = 32'h0000_0000;
            rresp_nxt = SCG_RESP_SLV;
         end
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         aw_held_r    <= 1'b0;
         w_held_r     <= 1'b0;
         awaddr_r     <= 32'h0000_0000;
         wdata_r      <= 32'h0000_0000;
         wstrb_r      <= 4'h0;
         bvalid_r     <= 1'b0;
         bresp_r      <= SCG_RESP_OKAY;
         rvalid_r     <= 1'b0;
         rresp_r      <= SCG_RESP_OKAY;
         rdata_r      <= 32'h0000_0000;
         run_gate_r   <= SCG_GATE_RST;
         sleep_gate_r <= SCG_GATE_RST;
         deep_gate_r  <= SCG_GATE_RST;
         auto_gating_select_r <= SCG_AUTO_RST;
         fault_stat_r <= SCG_UNITS_RST;
         fault_mask_r <= SCG_UNITS_RST;
      end
      else
      begin
         aw_held_r    <= aw_held_nxt;
         w_held_r     <= w_held_nxt;
         awaddr_r     <= awaddr_nxt;
         wdata_r      <= wdata_nxt;
         wstrb_r      <= wstrb_nxt;
         bvalid_r     <= bvalid_nxt;
         bresp_r      <= bresp_nxt;
         rvalid_r     <= rvalid_nxt;
         rresp_r      <= rresp_nxt;
         rdata_r      <= rdata_nxt;
         run_gate_r   <= run_gate_nxt;
         sleep_gate_r <= sleep_gate_nxt;
         deep_gate_r  <= deep_gate_nxt;
         auto_gating_select_r <= auto_gating_select_nxt;
         fault_stat_r <= fault_stat_nxt;
         fault_mask_r <= fault_mask_nxt;
      end
   end

   assign s_axi_awready = !aw_held_r;
   assign s_axi_wready  = !w_held_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rresp   = rresp_r;
   assign s_axi_rdata   = rdata_r;

   // ----------------------------------------------------------------
   // Power state and gating selection
   // ----------------------------------------------------------------
   always_comb
   begin
      if (deep_sleep_mode)
         pstate_nxt = SCG_PS_DEEP;
      else if (sleep_mode)
         pstate_nxt = SCG_PS_SLEEP;
      else
         pstate_nxt = SCG_PS_RUN;
      // Without auto gating the run settings hold in every state
      unit_en_nxt = gate_units(run_gate_r);
      case (pstate_r)
         SCG_PS_SLEEP:
            if (auto_gating_select_r)
               unit_en_nxt = gate_units(sleep_gate_r);
         SCG_PS_DEEP:
            if (auto_gating_select_r)
               unit_en_nxt = gate_units(deep_gate_r);
         default:
            unit_en_nxt = gate_units(run_gate_r);
      endcase
      disable_nxt = ~unit_en_r;
      fault_nxt   = |fault_hit;
      irq_nxt     = |(fault_stat_r & fault_mask_r);
   end

   always_ff @(posedge core_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         pstate_r  <= SCG_PS_RUN;
         unit_en_r <= SCG_UNITS_RST;
         disable_r <= ~SCG_UNITS_RST;
         fault_r   <= 1'b0;
         irq_r     <= 1'b0;
      end
      else
      begin
         pstate_r  <= pstate_nxt;
         unit_en_r <= unit_en_nxt;
         disable_r <= disable_nxt;
         fault_r   <= fault_nxt;
         irq_r     <= irq_nxt;
      end
   end

   assign unit_disable = disable_r;
   assign bus_fault    = fault_r;
   assign irq          = irq_r;

   // ----------------------------------------------------------------
   // Clock gates
   // ----------------------------------------------------------------
   for (genvar u = 0; u < SCG_UNITS; u++)
   begin : g_gate
      scg_gate_cell u_gate
      (
         .clk_i  (core_clk),
         .rst_i  (sys_rst),
         .en_i   (unit_en_r[u]),
         .gclk_o (unit_clk[u])
      );
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   property p_reserved_zero;
      ((sleep_gate_r & ~SCG_GATE_WMASK) == 32'h0000_0000);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved gating bits not zero");

   property p_sleep_select;
      (pstate_r == SCG_PS_SLEEP && auto_gating_select_r)
         |=> (unit_en_r == $past(gate_units(sleep_gate_r)));
   endproperty
   a_sleep_select: assert property (p_sleep_select)
      else $error("sleep gating not applied");

   property p_disable_follow;
      $changed(unit_en_r) |=> (unit_disable == ~$past(unit_en_r));
   endproperty
   a_disable_follow: assert property (p_disable_follow)
      else $error("gated unit not disabled");

   property p_fault_answer;
      (unit_access != 9'h000 && (unit_access & ~unit_en_r) != 9'h000) |=> bus_fault;
   endproperty
   a_fault_answer: assert property (p_fault_answer)
      else $error("access to gated unit without fault");

   property p_deep_select;
      (pstate_r == SCG_PS_DEEP && auto_gating_select_r)
         |=> (unit_en_r == $past(gate_units(deep_gate_r)));
   endproperty
   a_deep_select: assert property (p_deep_select)
      else $error("deep sleep gating not applied");

   property p_no_auto_sel;
      !auto_gating_select_r |=> (unit_en_r == $past(gate_units(run_gate_r)));
   endproperty
   a_no_auto_sel: assert property (p_no_auto_sel)
      else $error("sleep gating used without auto select");

   property p_sleep_write;
      (wr_fire && addr_hit(awaddr_r, SCG_OFS_SLEEP) && wstrb_r == 4'hF)
         |=> (sleep_gate_r == ($past(wdata_r) & SCG_GATE_WMASK)) && s_axi_bvalid;
   endproperty
   a_sleep_write: assert property (p_sleep_write)
      else $error("sleep gating write not stored");

   property p_irq_level;
      ((fault_stat_r & fault_mask_r) != 9'h000) |=> irq;
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("interrupt not raised");

   c_sleep_gated: cover property (pstate_r == SCG_PS_SLEEP && auto_gating_select_r
                                  && unit_en_r != 9'h000);
   c_fault:       cover property (bus_fault ##1 irq);
   c_read_sleep:  cover property (s_axi_arvalid && addr_hit(s_axi_araddr, SCG_OFS_SLEEP));

endmodule

/* verif/scg_unit_model.sv */
// Far-side model of the gated peripheral units.
// Assumes access strobes are launched just after a rising core_clk edge.
`timescale 1ns/1ps

module scg_unit_model
(
   // Clock
   input  wire logic                          core_clk,
   // Unit side
   input  wire logic [scg_pkg::SCG_UNITS-1:0] unit_clk,
   output logic      [scg_pkg::SCG_UNITS-1:0] unit_access
);
   import scg_pkg::*;

   // ----------------------------------------------------------------
   // Clock edge counters and access strobes
   // ----------------------------------------------------------------
   int edge_cnt [SCG_UNITS];

   initial unit_access = '0;

   // Counting real edges catches both missing and extra clock pulses
   for (genvar g = 0; g < SCG_UNITS; g++)
   begin : g_cnt
      always @(posedge unit_clk[g])
         edge_cnt[g] = edge_cnt[g] + 1;
   end

   task automatic clear_counts();
      foreach (edge_cnt[i])
         edge_cnt[i] = 0;
   endtask

   // One-cycle access from the unit's bus port
   task automatic touch(input int u);
      unit_access[u] <= 1'b1;
      @(posedge core_clk);
      unit_access <= '0;
   endtask
endmodule

/* verif/tb_top.sv */
// Self-checking bench for the sleep-mode clock gating controller.
// Assumes scg_pkg, scg_ctrl and scg_unit_model; acts as AXI4-Lite master.
`timescale 1ns/1ps

module tb_top;
   import scg_pkg::*;

   // ----------------------------------------------------------------
   // Design, partner and reference state
   // ----------------------------------------------------------------
   logic        core_clk, sys_rst, sleep_mode, deep_sleep_mode, bus_fault, irq;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [8:0]  unit_access, unit_clk, unit_disable, en;
   int          err_count, samples_checked;
   logic [31:0] m_run, m_slp, m_deep;
   logic [8:0]  m_stat, m_mask;
   logic        m_auto_sel;
   logic [11:0] offs [6] = '{12'h108, 12'h118, 12'h128, 12'h200, 12'h204, 12'h208};

   scg_ctrl uut
   (
      .core_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .sleep_mode, .deep_sleep_mode, .unit_access, .unit_clk, .unit_disable,
      .bus_fault, .irq
   );

   scg_unit_model u_units (.core_clk(core_clk), .unit_clk(unit_clk), .unit_access(unit_access));

   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   // ----------------------------------------------------------------
   // Reference model, compare and bus tasks
   // ----------------------------------------------------------------
   function automatic logic [1:0] pst();
      return deep_sleep_mode ? 2'h3 : (sleep_mode ? 2'h1 : 2'h0);
   endfunction

   function automatic logic [31:0] exp_rd(input logic [11:0] o);
      case (o)
         12'h108: return m_run;
         12'h118: return m_slp;
         12'h128: return m_deep;
         12'h200: return {29'h0, pst(), m_auto_sel};
         12'h204: return {23'h0, m_stat};
         12'h208: return {23'h0, m_mask};
         default: return 32'h0;
      endcase
   endfunction

   function automatic logic [8:0] exp_en();
      logic [31:0] g;
      g = (!m_auto_sel || pst() == 2'h0) ? m_run : (pst() == 2'h3 ? m_deep : m_slp);
      return {g[30], g[28], g[6:0]};
   endfunction

   task automatic report_and_stop();
      $display("Totals: %0d checks, %0d mismatches", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] %0t %s: got %h, expected %h", $time, what, got, exp);
      end
   endtask

   task automatic tmo(input string what);
      err_count++;
      $display("[ERR] %0t no answer to %s", $time, what);
      report_and_stop();
   endtask

   task automatic wr(input logic [11:0] o, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] bm, nv;
      logic [1:0]  r;
      int          n;
      bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      nv = (exp_rd(o) & ~bm) | (d & bm);
      n = 0;
      s_axi_awaddr <= SCG_BASE_ADDR | {20'h0, o};
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge core_clk);
         n++;
         r = s_axi_bresp;
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
         if (n > 60)
            tmo("write");
      end
      while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      // One idle edge so a following call never re-raises bready in this step
      @(posedge core_clk);
      chk({30'h0, r}, {30'h0, (o inside {offs}) ? SCG_RESP_OKAY : SCG_RESP_SLV}, "bresp");
      case (o)
         12'h108: m_run = nv & 32'h5000_007F;
         12'h118: m_slp = nv & 32'h5000_007F;
         12'h128: m_deep = nv & 32'h5000_007F;
         12'h200: m_auto_sel = nv[0];
         12'h204: m_stat = m_stat & ~(d[8:0] & bm[8:0]);
         12'h208: m_mask = nv[8:0];
         default: ;
      endcase
   endtask

   task automatic rd(input logic [11:0] o);
      logic [31:0] d;
      logic [1:0]  r;
      int          n;
      n = 0;
      s_axi_araddr <= SCG_BASE_ADDR | {20'h0, o};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge core_clk);
         n++;
         d = s_axi_rdata;
         r = s_axi_rresp;
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
         if (n > 60)
            tmo("read");
      end
      while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      @(posedge core_clk);
      chk(d, exp_rd(o), "read data");
      chk({30'h0, r}, {30'h0, (o inside {offs}) ? SCG_RESP_OKAY : SCG_RESP_SLV}, "rresp");
   endtask

   // Window of 8 falling edges holds exactly 8 rising edges of a live clock
   task automatic check_units();
      logic [8:0] on;
      @(negedge core_clk);
      u_units.clear_counts();
      repeat (8) @(negedge core_clk);
      for (int i = 0; i < SCG_UNITS; i++)
         on[i] = (u_units.edge_cnt[i] == 8) ? 1'b1 : ((u_units.edge_cnt[i] == 0) ? 1'b0 : 1'bx);
      chk({23'h0, on}, {23'h0, exp_en()}, "unit clocks");
      chk({23'h0, unit_disable}, {23'h0, ~exp_en()}, "unit disable");
      @(posedge core_clk);
   endtask

   task automatic do_reset(input int cycles);
      sys_rst <= 1'b1;
      repeat (cycles) @(posedge core_clk);
      sys_rst <= 1'b0;
      {m_run, m_slp, m_deep, m_stat, m_mask, m_auto_sel} = '0;
      @(posedge core_clk);
      chk({23'h0, unit_disable}, 32'h0000_01FF, "disable after reset");
      chk({31'h0, irq}, 32'h0, "irq after reset");
      foreach (offs[i])
         rd(offs[i]);
      $display("Test reset done");
   endtask

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial
   begin
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {sleep_mode, deep_sleep_mode} = '0;
      sys_rst = 1'b1;
      void'($urandom(32'hD768));
      do_reset(10);
      wr(12'h118, 32'hFFFF_FFFF, 4'hF);
      rd(12'h118);
      wr(12'h118, $urandom, 4'($urandom));
      rd(12'h118);
      wr(12'h118, exp_rd(12'h118) | 32'h0000_0001, 4'hF);
      wr(12'h108, $urandom, 4'hF);
      wr(12'h128, $urandom, 4'hF);
      rd(12'h108);
      rd(12'h128);
      wr(12'h11C, $urandom, 4'hF);
      rd(12'h11C);
      $display("Test registers done");
      for (int a = 0; a < 2; a++)
         for (int s = 0; s < 3; s++)
         begin
            wr(12'h200, 32'(a), 4'hF);
            sleep_mode <= (s == 1);
            deep_sleep_mode <= (s == 2);
            repeat (4) @(posedge core_clk);
            rd(12'h200);
            check_units();
         end
      $display("Test power states done");
      sleep_mode <= 1'b1;
      deep_sleep_mode <= 1'b0;
      wr(12'h118, 32'h4000_0005, 4'hF);
      repeat (4) @(posedge core_clk);
      check_units();
      for (int u = 0; u < SCG_UNITS; u++)
      begin
         en = exp_en();
         u_units.touch(u);
         #1;
         chk({31'h0, bus_fault}, {31'h0, !en[u]}, "bus fault");
         if (!en[u])
            m_stat[u] = 1'b1;
         @(posedge core_clk);
      end
      repeat (2) @(posedge core_clk);
      chk({31'h0, irq}, 32'h0, "irq while masked");
      rd(12'h204);
      wr(12'h208, 32'h0000_01FF, 4'hF);
      repeat (2) @(posedge core_clk);
      chk({31'h0, irq}, {31'h0, |(m_stat & m_mask)}, "irq unmasked");
      wr(12'h204, {23'h0, m_stat}, 4'hF);
      repeat (2) @(posedge core_clk);
      chk({31'h0, irq}, 32'h0, "irq after clear");
      rd(12'h204);
      $display("Test faults done");
      do_reset(2);
      report_and_stop();
   end
endmodule
